// [hdl/brownout_monitor_control.sv]
// How it works
// - rate bit picks 1 kHz or 125 Hz
// - rate bit from fuse, read-only
// - awake mode bits 3:2 from fuse, read-only
// - awake encoding off/continuous/sampled/hold-at-wake
// - sleep mode bits 1:0 writable, 3 reserved
// - sleep mode reset value from fuse
// - trip level bits 2:0 from fuse, read-only
// - margin field places warning above trip level
// - direction field selects below/above/either crossing
// - flag set on selected crossing
// - flag sets only while detector enabled, write clears it any time except in a cycle where it sets
// - status bit is one when below warning
// - monitor follows detector mode and sampling
// - sleep mode in standby, awake mode after
// - sleep write only within four instructions of key
// - interrupt held while flag and enable set
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "brownout_regs.svh"

module brownout_monitor_control
	import brownout_pkg::*;
#(
	parameter int unsigned FAST_CYC = `CLK_HZ / `SAMPLE_FAST_HZ,
	parameter int unsigned SLOW_CYC = `CLK_HZ / `SAMPLE_SLOW_HZ
) (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [5:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input  wire fuse_cfg_t   fuseCfg,
	input  wire logic        guardKeyWritten,
	input  wire logic        instrRetired,
	input  wire logic        deepSleep,
	input  wire logic        detectorReady,
	input  wire logic        belowWarning,
	output det_ctrl_t        detCtrl,
	output logic             cpuHold,
	output logic             irq
);

	function automatic logic isOn(input det_mode_t m);
		return m != DET_OFF;
	endfunction : isOn

	function automatic det_mode_t sleepEff(input logic [1:0] f);
		// reserved sleep code keeps the detector off
		return (f == DET_HOLD) ? DET_OFF : det_mode_t'(f);
	endfunction : sleepEff

	// bus slave: one wait state per access
	logic        ackR;
	logic        ack_nxt;
	logic [31:0] readdata_r;
	logic [31:0] readdata_nxt;
	logic [3:0]  idx;
	logic        wrEn;
	logic [7:0]  rdByte;

	// configuration
	logic       loadedR;
	logic       rate_r;
	det_mode_t  awake_r;
	logic [1:0] sleep_r;
	logic [2:0] level_r;
	logic [1:0] margin_r;
	warn_dir_t  dir_r;
	logic       ie_r;
	logic       loaded_nxt;
	logic       rate_nxt;
	det_mode_t  awake_nxt;
	logic [1:0] sleep_nxt;
	logic [2:0] level_nxt;
	logic [1:0] margin_nxt;
	warn_dir_t  dir_nxt;
	logic       ie_nxt;

	// protection window
	logic [2:0] guard_r;
	logic [2:0] guard_nxt;
	logic       guardOpen;
	logic       sleepWr;

	// power state and detector mode
	pwr_state_t state_r;
	pwr_state_t state_nxt;
	det_mode_t  mode_r;
	det_mode_t  mode_nxt;

	// sampler
	logic [`SAMPLE_CNT_W-1:0] cnt_r;
	logic [`SAMPLE_CNT_W-1:0] cnt_nxt;
	logic [`SAMPLE_CNT_W-1:0] period;
	logic                     pulse_r;
	logic                     pulse_nxt;

	// monitor
	logic status_r;
	logic status_nxt;
	logic flag_r;
	logic flag_nxt;
	logic take;
	logic setEv;
	logic clrEv;

	assign idx         = address[5:2];
	assign waitrequest = (read | write) & ~ackR;
	assign wrEn        = write & ackR & byteenable[0];
	assign readdata    = readdata_r;

	always_comb begin
		rdByte = 8'h00;
		unique case (idx)
			`IDX_MODE_CTRL: begin
				rdByte[`F_RATE]                  = rate_r;
				rdByte[`F_AWAKE_HI:`F_AWAKE_LO] = awake_r;
				rdByte[`F_SLEEP_HI:`F_SLEEP_LO] = sleep_r;
			end
			`IDX_LEVEL:     rdByte[`F_LEVEL_HI:0]         = level_r;
			`IDX_MARGIN:    rdByte[`F_MARGIN_HI:0]        = margin_r;
			`IDX_IRQ_CTRL: begin
				rdByte[`F_DIR_HI:`F_DIR_LO] = dir_r;
				rdByte[`F_IE]               = ie_r;
			end
			`IDX_IRQ_FLAGS: rdByte[`F_FLAG]               = flag_r;
			`IDX_STATUS:    rdByte[`F_STAT]               = status_r;
			default:        rdByte = 8'h00;
		endcase
	end

	always_comb begin
		ack_nxt      = (read | write) & ~ackR;
		readdata_nxt = readdata_r;
		if (read && !ackR) begin
			readdata_nxt = {24'h00_0000, rdByte};
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ackR       <= 1'b0;
			readdata_r <= 32'h0000_0000;
		end else begin
			ackR       <= ack_nxt;
			readdata_r <= readdata_nxt;
		end
	end

	// key opens a window of instruction retirements
	assign guardOpen = guard_r != `GUARD_RST;
	assign sleepWr   = wrEn && idx == `IDX_MODE_CTRL;

	always_comb begin
		guard_nxt = guard_r;
		if (guardKeyWritten) begin
			guard_nxt = `GUARD_INSTR;
		end else if (sleepWr) begin
			guard_nxt = `GUARD_RST;
		end else if (instrRetired && guardOpen) begin
			guard_nxt = guard_r - 3'h1;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			guard_r <= `GUARD_RST;
		end else begin
			guard_r <= guard_nxt;
		end
	end

	// fuse is captured on the first edge after reset release
	always_comb begin
		loaded_nxt = 1'b1;
		rate_nxt   = rate_r;
		awake_nxt  = awake_r;
		sleep_nxt  = sleep_r;
		level_nxt  = level_r;
		margin_nxt = margin_r;
		dir_nxt    = dir_r;
		ie_nxt     = ie_r;
		if (!loadedR) begin
			rate_nxt  = fuseCfg.sampleRateSel;
			awake_nxt = fuseCfg.awakeMode;
			sleep_nxt = fuseCfg.sleepMode;
			level_nxt = fuseCfg.tripLevel;
		end else if (wrEn) begin
			if (idx == `IDX_MODE_CTRL && guardOpen) begin
				sleep_nxt = writedata[`F_SLEEP_HI:`F_SLEEP_LO];
			end
			if (idx == `IDX_MARGIN) begin
				margin_nxt = writedata[`F_MARGIN_HI:0];
			end
			if (idx == `IDX_IRQ_CTRL) begin
				dir_nxt = warn_dir_t'(writedata[`F_DIR_HI:`F_DIR_LO]);
				ie_nxt  = writedata[`F_IE];
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			loadedR  <= 1'b0;
			rate_r   <= 1'b0;
			awake_r  <= DET_OFF;
			sleep_r  <= 2'h0;
			level_r  <= 3'h0;
			margin_r <= `MARGIN_RST;
			dir_r    <= warn_dir_t'(`DIR_RST);
			ie_r     <= 1'b0;
		end else begin
			loadedR  <= loaded_nxt;
			rate_r   <= rate_nxt;
			awake_r  <= awake_nxt;
			sleep_r  <= sleep_nxt;
			level_r  <= level_nxt;
			margin_r <= margin_nxt;
			dir_r    <= dir_nxt;
			ie_r     <= ie_nxt;
		end
	end

	// standby/power-down tracking and hold at wake
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			PS_ACTIVE: if (deepSleep) state_nxt = PS_SLEEP;
			PS_SLEEP:  if (!deepSleep) state_nxt = PS_WAKE;
			PS_WAKE: begin
				if (deepSleep) begin
					state_nxt = PS_SLEEP;
				end else if (awake_r != DET_HOLD || detectorReady) begin
					state_nxt = PS_ACTIVE;
				end
			end
			default:   state_nxt = PS_ACTIVE;
		endcase
		if (!loadedR) begin
			mode_nxt = DET_OFF;
		end else if (state_nxt == PS_SLEEP) begin
			mode_nxt = sleepEff(sleep_r);
		end else begin
			mode_nxt = awake_r;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r <= PS_ACTIVE;
			mode_r  <= DET_OFF;
		end else begin
			state_r <= state_nxt;
			mode_r  <= mode_nxt;
		end
	end

	assign cpuHold = state_r == PS_WAKE && awake_r == DET_HOLD;

	// sample strobe only in sampled mode
	assign period = rate_r ? `SAMPLE_CNT_W'(SLOW_CYC) : `SAMPLE_CNT_W'(FAST_CYC);

	always_comb begin
		cnt_nxt   = '0;
		pulse_nxt = 1'b0;
		if (mode_r == DET_SAMP) begin
			if (cnt_r == '0) begin
				pulse_nxt = 1'b1;
				cnt_nxt   = period - `SAMPLE_CNT_W'(1);
			end else begin
				cnt_nxt = cnt_r - `SAMPLE_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_r   <= '0;
			pulse_r <= 1'b0;
		end else begin
			cnt_r   <= cnt_nxt;
			pulse_r <= pulse_nxt;
		end
	end

	// monitor only looks while the detector runs
	assign take  = isOn(mode_r) && detectorReady && (mode_r != DET_SAMP || pulse_r);
	assign clrEv = wrEn && writedata[`F_FLAG] &&
		(idx == `IDX_IRQ_FLAGS || idx == `IDX_IRQ_CLEAR);

	always_comb begin
		setEv = 1'b0;
		if (take) begin
			unique case (dir_r)
				DIR_BELOW: setEv = belowWarning && !status_r;
				DIR_ABOVE: setEv = !belowWarning && status_r;
				DIR_CROSS: setEv = belowWarning != status_r;
				DIR_RSVD:  setEv = 1'b0;
			endcase
		end
		status_nxt = take ? belowWarning : status_r;
		flag_nxt   = setEv | (flag_r & ~clrEv);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			status_r <= 1'b0;
			flag_r   <= 1'b0;
		end else begin
			status_r <= status_nxt;
			flag_r   <= flag_nxt;
		end
	end

	assign irq                   = flag_r & ie_r;
	assign detCtrl = '{mode: mode_r, samplePulse: pulse_r, tripLevel: level_r,
		warningMargin: margin_r};

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence goSleep;
		loadedR && state_r == PS_ACTIVE && deepSleep;
	endsequence

	sequence wakeUp;
		state_r == PS_SLEEP && !deepSleep ##1 state_r == PS_WAKE;
	endsequence

	a_sleep_mode: assert property (goSleep |=> mode_r == sleepEff(sleep_r))
		else $error("detector not in sleep mode after entering standby");
	a_wake_mode: assert property (wakeUp |-> mode_r == awake_r)
		else $error("detector not back in awake mode after wake");
	a_sleep_locked: assert property (loadedR && sleepWr && !guardOpen
		|=> sleep_r == $past(sleep_r))
		else $error("sleep mode changed without key");
	a_awake_fixed: assert property (loadedR |=> awake_r == $past(awake_r))
		else $error("awake mode changed after load");
	a_rate_fixed: assert property (loadedR |=> rate_r == $past(rate_r) &&
		level_r == $past(level_r))
		else $error("rate or level changed after load");
	a_rate_reload: assert property (pulse_r && mode_r == DET_SAMP
		|-> cnt_r == period - `SAMPLE_CNT_W'(1))
		else $error("sample period reload wrong");
	a_set_wins: assert property (setEv |=> flag_r [*1] ##0 irq == ie_r)
		else $error("flag event lost");
	a_flag_frozen: assert property (!isOn(mode_r) && !clrEv |=> flag_r == $past(flag_r))
		else $error("flag changed while detector off");
	a_irq_holds: assert property (irq && !clrEv |=> flag_r)
		else $error("interrupt dropped before flag clear");
	a_status_cont: assert property (mode_r == DET_CONT && detectorReady
		|=> status_r == $past(belowWarning))
		else $error("status does not follow comparator");
	a_reserved_zero: assert property (read && !ackR && idx > `IDX_LEVEL && idx < `IDX_MARGIN
		|=> readdata == 32'h0000_0000)
		else $error("reserved offset read not zero");

endmodule : brownout_monitor_control
`default_nettype wire

// [hdl/brownout_regs.svh]
`ifndef BROWNOUT_REGS_SVH
`define BROWNOUT_REGS_SVH

// register indices; byte address is four times the index
`define IDX_MODE_CTRL   4'h0
`define IDX_LEVEL       4'h1
`define IDX_MARGIN      4'h8
`define IDX_IRQ_CTRL    4'h9
`define IDX_IRQ_FLAGS   4'hA
`define IDX_STATUS      4'hB
`define IDX_IRQ_CLEAR   4'hC

// field positions
`define F_RATE          4
`define F_AWAKE_HI      3
`define F_AWAKE_LO      2
`define F_SLEEP_HI      1
`define F_SLEEP_LO      0
`define F_LEVEL_HI      2
`define F_MARGIN_HI     1
`define F_DIR_HI        2
`define F_DIR_LO        1
`define F_IE            0
`define F_FLAG          0
`define F_STAT          0

// reset values
`define MARGIN_RST      2'h0
`define DIR_RST         2'h0
`define GUARD_RST       3'h0

// timing
`define CLK_HZ          50000000
`define SAMPLE_FAST_HZ  1000
`define SAMPLE_SLOW_HZ  125
`define SAMPLE_CNT_W    19
`define GUARD_INSTR     3'h4

`endif

// [hdl/brownout_pkg.sv]
package brownout_pkg;
	typedef enum logic [1:0] {
		DET_OFF  = 2'h0,
		DET_CONT = 2'h1,
		DET_SAMP = 2'h2,
		DET_HOLD = 2'h3
	} det_mode_t;

	typedef enum logic [1:0] {
		DIR_BELOW = 2'h0,
		DIR_ABOVE = 2'h1,
		DIR_CROSS = 2'h2,
		DIR_RSVD  = 2'h3
	} warn_dir_t;

	typedef enum logic [1:0] {
		PS_ACTIVE = 2'h0,
		PS_SLEEP  = 2'h1,
		PS_WAKE   = 2'h3
	} pwr_state_t;

	typedef struct packed {
		logic       sampleRateSel;
		det_mode_t  awakeMode;
		logic [1:0] sleepMode;
		logic [2:0] tripLevel;
	} fuse_cfg_t;

	typedef struct packed {
		det_mode_t  mode;
		logic       samplePulse;
		logic [2:0] tripLevel;
		logic [1:0] warningMargin;
	} det_ctrl_t;
endpackage : brownout_pkg

// [bench/supply_model.sv]
`timescale 1ns/1ps
`default_nettype none

module supply_model
	import brownout_pkg::*;
(
	input  wire logic      clk,
	input  wire det_ctrl_t detCtrl,
	input  wire logic      supplyLow,
	output logic           belowWarning,
	output logic           detectorReady
);
	logic [1:0] upCnt_r;

	initial begin
		upCnt_r = 2'h0;
		belowWarning = 1'b0;
		detectorReady = 1'b0;
	end

	// comparator output is meaningless while the detector is off
	always @(posedge clk) begin
		if (detCtrl.mode == DET_OFF) begin
			upCnt_r <= 2'h0;
			detectorReady <= 1'b0;
			belowWarning <= ~belowWarning;
		end else begin
			upCnt_r <= upCnt_r + {1'b0, upCnt_r != 2'h3};
			detectorReady <= (upCnt_r == 2'h3);
			belowWarning <= supplyLow;
		end
	end
endmodule : supply_model

`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench
	import brownout_pkg::*;
;
	logic        clk, reset, read, write, waitrequest, irq, cpuHold;
	logic        guardKeyWritten, instrRetired, deepSleep, supplyLow;
	logic        detectorReady, belowWarning;
	logic [5:0]  address;
	logic [31:0] writedata, readdata;
	logic [3:0]  byteenable;
	fuse_cfg_t   fuseCfg;
	det_ctrl_t   detCtrl;
	logic [7:0]  q;
	int          fail_count, comparisons, i, n;
	logic [5:0]  ra [8] = '{6'h00, 6'h04, 6'h08, 6'h1C, 6'h20, 6'h24, 6'h28, 6'h2C};
	logic [7:0]  re [8] = '{8'h14, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

	brownout_monitor_control #(.FAST_CYC(8), .SLOW_CYC(20)) u_brownout_monitor_control (
		.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .fuseCfg(fuseCfg), .guardKeyWritten(guardKeyWritten),
		.instrRetired(instrRetired), .deepSleep(deepSleep), .detectorReady(detectorReady),
		.belowWarning(belowWarning), .detCtrl(detCtrl), .cpuHold(cpuHold), .irq(irq));

	supply_model u_supply_model (.clk(clk), .detCtrl(detCtrl), .supplyLow(supplyLow),
		.belowWarning(belowWarning), .detectorReady(detectorReady));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task close_out;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : close_out

	task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
		int k;
		@(posedge clk);
		address <= a;
		writedata <= {24'h00_0000, d};
		read <= ~wr;
		write <= wr;
		for (k = 0; k < 16; k++) begin
			@(posedge clk);
			if (waitrequest === 1'b0) break;
		end
		if (k == 16) begin
			fail_count++;
			close_out();
		end
		q = readdata[7:0];
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus

	// which 0 pulses the key, 1 retires an instruction
	task pulse(input int which);
		@(posedge clk);
		if (which == 0) guardKeyWritten <= 1'b1;
		else instrRetired <= 1'b1;
		@(posedge clk);
		guardKeyWritten <= 1'b0;
		instrRetired <= 1'b0;
	endtask : pulse

	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		close_out();
	end

	initial begin
		fail_count = 0;
		comparisons = 0;
		reset = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = 6'h00;
		writedata = 32'h0000_0000;
		byteenable = 4'hF;
		fuseCfg = '{sampleRateSel: 1'b1, awakeMode: DET_CONT, sleepMode: 2'h0, tripLevel: 3'h5};
		guardKeyWritten = 1'b0;
		instrRetired = 1'b0;
		deepSleep = 1'b0;
		supplyLow = 1'b0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		repeat (2) @(posedge clk);
		for (i = 0; i < 8; i++) begin
			bus(1'b0, ra[i], 8'h00);
			chk("resetRead", re[i], q);
		end
		chk("tripOut", 8'h05, {5'h00, detCtrl.tripLevel});
		bus(1'b1, 6'h00, 8'hFF);
		bus(1'b0, 6'h00, 8'h00);
		chk("unkeyed", 8'h14, q);
		pulse(0);
		bus(1'b1, 6'h00, 8'hFE);
		bus(1'b0, 6'h00, 8'h00);
		chk("keyed", 8'h16, q);
		pulse(0);
		for (i = 0; i < 4; i++) pulse(1);
		bus(1'b1, 6'h00, 8'h01);
		bus(1'b0, 6'h00, 8'h00);
		chk("expired", 8'h16, q);
		deepSleep <= 1'b1;
		repeat (3) @(posedge clk);
		chk("sleepMode", {6'h00, DET_SAMP}, {6'h00, detCtrl.mode});
		for (n = 0; n < 50 && detCtrl.samplePulse !== 1'b1; n++) @(negedge clk);
		@(negedge clk);
		for (n = 1; n < 50 && detCtrl.samplePulse !== 1'b1; n++) @(negedge clk);
		chk("samplePeriod", 8'h14, n[7:0]);
		@(posedge clk);
		deepSleep <= 1'b0;
		repeat (3) @(posedge clk);
		chk("awakeMode", {6'h00, DET_CONT}, {6'h00, detCtrl.mode});
		chk("cpuHold", 8'h00, {7'h00, cpuHold});
		pulse(0);
		bus(1'b1, 6'h00, 8'h00);
		bus(1'b1, 6'h20, 8'hFF);
		bus(1'b0, 6'h20, 8'h00);
		chk("margin", 8'h03, q);
		byteenable <= 4'h0;
		bus(1'b1, 6'h24, 8'h01);
		byteenable <= 4'hF;
		bus(1'b0, 6'h24, 8'h00);
		chk("noLane", 8'h00, q);
		bus(1'b1, 6'h24, 8'h01);
		supplyLow <= 1'b1;
		repeat (4) @(posedge clk);
		chk("irqBelow", 8'h01, {7'h00, irq});
		bus(1'b0, 6'h2C, 8'h00);
		chk("status", 8'h01, q);
		bus(1'b1, 6'h24, 8'h00);
		@(posedge clk);
		chk("irqMasked", 8'h00, {7'h00, irq});
		bus(1'b1, 6'h28, 8'h01);
		bus(1'b0, 6'h28, 8'h00);
		chk("cleared", 8'h00, q);
		bus(1'b1, 6'h24, 8'h03);
		supplyLow <= 1'b0;
		repeat (4) @(posedge clk);
		bus(1'b0, 6'h28, 8'h00);
		chk("flagAbove", 8'h01, q);
		chk("irqAbove", 8'h01, {7'h00, irq});
		bus(1'b1, 6'h28, 8'h01);
		bus(1'b1, 6'h24, 8'h05);
		deepSleep <= 1'b1;
		supplyLow <= 1'b1;
		repeat (6) @(posedge clk);
		chk("offMode", 8'h00, {6'h00, detCtrl.mode});
		bus(1'b0, 6'h28, 8'h00);
		chk("flagHeld", 8'h00, q);
		deepSleep <= 1'b0;
		repeat (8) @(posedge clk);
		bus(1'b0, 6'h28, 8'h00);
		chk("crossDown", 8'h01, q);
		bus(1'b1, 6'h28, 8'h01);
		supplyLow <= 1'b0;
		repeat (4) @(posedge clk);
		bus(1'b0, 6'h28, 8'h00);
		chk("crossUp", 8'h01, q);
		fuseCfg <= '{sampleRateSel: 1'b0, awakeMode: DET_HOLD, sleepMode: 2'h3, tripLevel: 3'h2};
		reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		repeat (2) @(posedge clk);
		bus(1'b0, 6'h00, 8'h00);
		chk("fuseHold", 8'h0F, q);
		bus(1'b0, 6'h04, 8'h00);
		chk("fuseLevel", 8'h02, q);
		deepSleep <= 1'b1;
		repeat (3) @(posedge clk);
		chk("rsvdSleep", 8'h00, {6'h00, detCtrl.mode});
		deepSleep <= 1'b0;
		repeat (2) @(posedge clk);
		chk("holdWake", 8'h01, {7'h00, cpuHold});
		chk("holdMode", {6'h00, DET_HOLD}, {6'h00, detCtrl.mode});
		repeat (6) @(posedge clk);
		chk("holdDone", 8'h00, {7'h00, cpuHold});
		close_out();
	end
endmodule : testbench

`default_nettype wire
